// ---- hdl/ppoc_pkg.sv ----
package ppoc_pkg;
  // Register map, word aligned byte address
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STAT_ADDR = 4'h4;
  localparam logic [15:0] CTRL_RESET = 16'hC000;
  // Field positions
  localparam int HI_OWN_BIT  = 15;
  localparam int LO_OWN_BIT  = 14;
  localparam int HI_POL_BIT  = 13;
  localparam int LO_POL_BIT  = 12;
  localparam int MODE_LSB    = 10;
  localparam int HI_OVR_BIT  = 9;
  localparam int LO_OVR_BIT  = 8;
  localparam int OVR_LSB     = 6;
  localparam int FLT_LSB     = 4;
  localparam int CL_LSB      = 2;
  // Pair output modes
  typedef enum logic [1:0] {
    PPOC_COMPL  = 2'h0,
    PPOC_REDUND = 2'h1,
    PPOC_PUSHPL = 2'h2,
    PPOC_INDEP  = 2'h3
  } ppoc_mode_t;
  // Drive sources for one pin
  typedef struct packed {
    logic gen;
    logic own;
    logic pol;
    logic ovrEn;
    logic ovr;
    logic flt;
    logic cl;
  } ppoc_pin_t;
endpackage

// ---- hdl/ppoc_pin_stage.sv ----
`timescale 1ns/100ps
module ppoc_pin_stage (
  // Clock and control
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Pin inputs
  input  wire ppoc_pkg::ppoc_pin_t cfg,
  input  wire logic             fltActive,
  input  wire logic             clActive,
  input  wire logic             gpioOut,
  // Pin output
  output logic                  pinOut
);
  logic pinQ;
  logic pinD;

  always_comb begin
    if (!cfg.own) begin
      pinD = gpioOut;
    end else if (fltActive) begin
      pinD = cfg.flt;
    end else if (clActive) begin
      pinD = cfg.cl;
    end else if (cfg.ovrEn) begin
      pinD = cfg.ovr;
    end else begin
      pinD = cfg.gen ^ cfg.pol;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinQ <= 1'b0;
    end else if (ce) begin
      pinQ <= pinD;
    end
  end

  assign pinOut = pinQ;
endmodule

// ---- hdl/ppoc_top.sv ----
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/100ps
// Contract
// - Bit 15 gives the high pin to the generator when set, else to the port logic.
// - Bit 14 gives the low pin to the generator when set, else to the port logic.
// - Bit 13 set makes the high pin active low.
// - Bit 12 set makes the low pin active low.
// - Bits 11-10 pick complementary, redundant or independent pairing; push-pull code 2 steers the low pin like independent.
// - Bit 9 set forces the high pin to the upper override level unless an enabled fault or current limit is active.
// - Bit 8 set forces the low pin to the lower override level unless an enabled fault or current limit is active.
// - Bits 7-6 hold the override levels, high then low.
// - An enabled active fault drives the high pin to fault bit 5.
// - An enabled active fault drives the low pin to fault bit 4.
// - An enabled active current limit drives the high pin to bit 3 unless an enabled fault is active.
module ppoc_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Wishbone slave
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [3:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatI,
  output logic [31:0]      wbDatO,
  output logic             wbAck,
  // Generator and condition inputs
  input  wire logic        genHigh,
  input  wire logic        genLow,
  input  wire logic        faultActive,
  input  wire logic        faultHandlingMode,
  input  wire logic        currentLimitActive,
  input  wire logic        currentLimitHandlingMode,
  input  wire logic        gpioHigh,
  input  wire logic        gpioLow,
  // Pins
  output logic             highSideOutput,
  output logic             lowSideOutput
);
  logic [15:0] ctrlQ;
  logic [15:0] ctrlD;
  logic        ackQ;
  logic        ackD;
  logic [31:0] datQ;
  logic [31:0] datD;
  logic        hiGen;
  logic        loGen;
  logic        fltOn;
  logic        clOn;
  ppoc_pkg::ppoc_mode_t mode;
  ppoc_pkg::ppoc_pin_t  hiCfg;
  ppoc_pkg::ppoc_pin_t  loCfg;

  // Bus access
  logic busReq;
  assign busReq = wbCyc && wbStb && !ackQ;

  always_comb begin
    ctrlD = ctrlQ;
    ackD  = busReq;
    datD  = 32'h0000_0000;
    if (busReq && wbWe && wbAdr == ppoc_pkg::CTRL_ADDR) begin
      if (wbSel[0]) ctrlD[7:0] = wbDatI[7:0];
      if (wbSel[1]) ctrlD[15:8] = wbDatI[15:8];
    end
    if (busReq && !wbWe) begin
      unique case (wbAdr)
        ppoc_pkg::CTRL_ADDR: datD = {16'h0000, ctrlQ};
        ppoc_pkg::STAT_ADDR: datD = {26'h0000000, fltOn, clOn, genHigh, genLow,
                                     highSideOutput, lowSideOutput};
        default:             datD = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlQ <= ppoc_pkg::CTRL_RESET;
      ackQ  <= 1'b0;
      datQ  <= 32'h0000_0000;
    end else if (ce) begin
      ctrlQ <= ctrlD;
      ackQ  <= ackD;
      datQ  <= datD;
    end
  end

  assign wbAck  = ackQ;
  assign wbDatO = datQ;

  // Pair mode steering of generator outputs
  assign mode = ppoc_pkg::ppoc_mode_t'(ctrlQ[ppoc_pkg::MODE_LSB +: 2]);
  always_comb begin
    hiGen = genHigh;
    loGen = genLow;
    unique case (mode)
      ppoc_pkg::PPOC_COMPL:  loGen = ~genHigh;
      ppoc_pkg::PPOC_REDUND: loGen = genHigh;
      ppoc_pkg::PPOC_PUSHPL: loGen = genLow;
      ppoc_pkg::PPOC_INDEP:  loGen = genLow;
    endcase
  end

  assign fltOn = faultActive && faultHandlingMode;
  assign clOn  = currentLimitActive && currentLimitHandlingMode;

  always_comb begin
    hiCfg.gen   = hiGen;
    hiCfg.own   = ctrlQ[ppoc_pkg::HI_OWN_BIT];
    hiCfg.pol   = ctrlQ[ppoc_pkg::HI_POL_BIT];
    hiCfg.ovrEn = ctrlQ[ppoc_pkg::HI_OVR_BIT];
    hiCfg.ovr   = ctrlQ[ppoc_pkg::OVR_LSB + 1];
    hiCfg.flt   = ctrlQ[ppoc_pkg::FLT_LSB + 1];
    hiCfg.cl    = ctrlQ[ppoc_pkg::CL_LSB + 1];
    loCfg.gen   = loGen;
    loCfg.own   = ctrlQ[ppoc_pkg::LO_OWN_BIT];
    loCfg.pol   = ctrlQ[ppoc_pkg::LO_POL_BIT];
    loCfg.ovrEn = ctrlQ[ppoc_pkg::LO_OVR_BIT];
    loCfg.ovr   = ctrlQ[ppoc_pkg::OVR_LSB];
    loCfg.flt   = ctrlQ[ppoc_pkg::FLT_LSB];
    loCfg.cl    = ctrlQ[ppoc_pkg::CL_LSB];
  end

  ppoc_pin_stage uHigh (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .cfg       (hiCfg),
    .fltActive (fltOn),
    .clActive  (clOn),
    .gpioOut   (gpioHigh),
    .pinOut    (highSideOutput)
  );

  ppoc_pin_stage uLow (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .cfg       (loCfg),
    .fltActive (fltOn),
    .clActive  (clOn),
    .gpioOut   (gpioLow),
    .pinOut    (lowSideOutput)
  );

  // Checks wait two edges after reset so pins reset low are not judged
  logic [1:0] chkArmQ;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chkArmQ <= 2'h0;
    end else begin
      chkArmQ <= {chkArmQ[0], 1'b1};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !chkArmQ[1]);

  high_owner_a: assert property (ce && !ctrlQ[15] |=> highSideOutput == $past(gpioHigh))
    else $error("high pin not from port logic");
  low_owner_a: assert property (ce && !ctrlQ[14] |=> lowSideOutput == $past(gpioLow))
    else $error("low pin not from port logic");
  high_pol_a: assert property (ce && ctrlQ[15] && !fltOn && !clOn && !ctrlQ[9]
      |=> highSideOutput == ($past(genHigh) ^ $past(ctrlQ[13])))
    else $error("high polarity wrong");
  low_pol_a: assert property (ce && ctrlQ[14] && !fltOn && !clOn && !ctrlQ[8]
      && ctrlQ[11:10] == 2'h3 |=> lowSideOutput == ($past(genLow) ^ $past(ctrlQ[12])))
    else $error("low polarity wrong");
  compl_mode_a: assert property (ce && ctrlQ[14] && !fltOn && !clOn && !ctrlQ[8]
      && ctrlQ[11:10] == 2'h0 |=> lowSideOutput == (!$past(genHigh) ^ $past(ctrlQ[12])))
    else $error("complementary low wrong");
  redund_mode_a: assert property (ce && ctrlQ[14] && !fltOn && !clOn && !ctrlQ[8]
      && ctrlQ[11:10] == 2'h1 |=> lowSideOutput == ($past(genHigh) ^ $past(ctrlQ[12])))
    else $error("redundant low wrong");
  high_ovr_a: assert property (ce && ctrlQ[15] && !fltOn && !clOn && ctrlQ[9]
      |=> highSideOutput == $past(ctrlQ[7]))
    else $error("high override wrong");
  low_ovr_a: assert property (ce && ctrlQ[14] && !fltOn && !clOn && ctrlQ[8]
      |=> lowSideOutput == $past(ctrlQ[6]))
    else $error("low override wrong");
  ovr_data_a: assert property (ce && ctrlQ[15] && ctrlQ[14] && !fltOn && !clOn
      && ctrlQ[9] && ctrlQ[8] |=> {highSideOutput, lowSideOutput} == $past(ctrlQ[7:6]))
    else $error("override pair wrong");
  high_fault_a: assert property (ce && ctrlQ[15] && fltOn
      |=> highSideOutput == $past(ctrlQ[5]))
    else $error("high fault level wrong");
  low_fault_a: assert property (ce && ctrlQ[14] && fltOn
      |=> lowSideOutput == $past(ctrlQ[4]))
    else $error("low fault level wrong");
  high_limit_a: assert property (ce && ctrlQ[15] && !fltOn && clOn
      |=> highSideOutput == $past(ctrlQ[3]))
    else $error("high limit level wrong");
  low_limit_a: assert property (ce && ctrlQ[14] && !fltOn && clOn
      |=> lowSideOutput == $past(ctrlQ[2]))
    else $error("low limit level wrong");

  write_seen_c: cover property (ce && busReq && wbWe ##1 wbAck);
  fault_seen_c: cover property (fltOn && ctrlQ[15]);
  limit_seen_c: cover property (clOn && !fltOn && ctrlQ[14]);
  compl_seen_c: cover property (ctrlQ[11:10] == 2'h0 && ctrlQ[14] && genHigh);
endmodule

// ---- tb/ppoc_gate_drv.sv ----
`timescale 1ns/100ps
module ppoc_gate_drv (
  // Clock
  input  wire logic clk,
  // Pins in, gate levels out
  input  wire logic highSideOutput,
  input  wire logic lowSideOutput,
  output logic      gateHigh,
  output logic      gateLow
);
  // Gate driver delays the pin levels by one cycle
  always_ff @(posedge clk) begin
    gateHigh <= highSideOutput;
    gateLow  <= lowSideOutput;
  end
endmodule

// ---- tb/test_pwm_pin_output_control.sv ----
`timescale 1ns/100ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD %0t mismatch", $time); end end
module test_pwm_pin_output_control;
  logic clk, rst, wbCyc, wbStb, wbWe, wbAck, hiP, loP;
  logic [3:0] wbAdr;
  logic [31:0] wbDatI, wbDatO, rd;
  logic genHigh, genLow, fA, fM, cA, cM, gpioHigh, gpioLow;
  logic [15:0] c;
  int mismatches, nTests, cyc;
  ppoc_top ppoc_top_inst (.clk(clk), .rst(rst), .ce(1'b1), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(4'h3), .wbDatI(wbDatI), .wbDatO(wbDatO),
    .wbAck(wbAck), .genHigh(genHigh), .genLow(genLow), .faultActive(fA),
    .faultHandlingMode(fM), .currentLimitActive(cA), .currentLimitHandlingMode(cM),
    .gpioHigh(gpioHigh), .gpioLow(gpioLow), .highSideOutput(hiP), .lowSideOutput(loP));
  ppoc_gate_drv ppoc_gate_drv_inst (.clk(clk), .highSideOutput(hiP),
    .lowSideOutput(loP), .gateHigh(), .gateLow());
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task end_sim;
    if (mismatches == 0 && nTests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      mismatches++;
      end_sim;
    end
  end
  task wb(input logic we, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= a; wbDatI <= {16'hFFFF, d};
    do @(posedge clk); while (wbAck !== 1'b1);
    rd = wbDatO;
    wbCyc <= 1'b0; wbStb <= 1'b0;
    if (we) c = d;
  endtask
  function logic e(input logic hi);
    logic g;
    g = hi ? genHigh : (c[11:10] == 2'h0 ? ~genHigh : c[11:10] == 2'h1 ? genHigh : genLow);
    if (!(hi ? c[15] : c[14])) return hi ? gpioHigh : gpioLow;
    if (fA && fM) return hi ? c[5] : c[4];
    if (cA && cM) return hi ? c[3] : c[2];
    if (hi ? c[9] : c[8]) return hi ? c[7] : c[6];
    return g ^ (hi ? c[13] : c[12]);
  endfunction
  task pins(input logic [7:0] v);
    {genHigh, genLow, fA, fM, cA, cM, gpioHigh, gpioLow} <= v;
    repeat (2) @(posedge clk);
    #1;
    `CHK(hiP, e(1'b1))
    `CHK(loP, e(1'b0))
  endtask
  task tReg;
    wb(1'b0, 4'h0, 16'h0);
    `CHK(rd, 32'h0000C000)
    wb(1'b1, 4'h0, 16'hA5FC);
    wb(1'b0, 4'h0, 16'h0);
    `CHK(rd, 32'h0000A5FC)
    wb(1'b0, 4'h8, 16'h0);
    `CHK(rd, 32'h00000000)
  endtask
  task tOwn;
    wb(1'b1, 4'h0, 16'h0000);
    pins(8'hC2);
    pins(8'h01);
    wb(1'b1, 4'h0, 16'h8000);
    pins(8'h41);
  endtask
  task tModes;
    for (int m = 0; m < 16; m++) begin
      wb(1'b1, 4'h0, 16'hC000 | 16'(m) << 10);
      pins(8'h80);
      pins(8'h40);
    end
  endtask
  task tForce;
    wb(1'b1, 4'h0, 16'hC3A4);
    pins(8'hC0);
    wb(1'b1, 4'h0, 16'hC240);
    pins(8'h00);
    wb(1'b1, 4'h0, 16'hF3E4);
    pins(8'h30);
    pins(8'h0C);
    pins(8'h24);
    pins(8'h3C);
    wb(1'b0, 4'h4, 16'h0);
    `CHK(rd, 32'h00000032)
  endtask
  initial begin
    rst = 1'b1; wbCyc = 1'b0; wbStb = 1'b0; wbWe = 1'b0; wbAdr = 4'h0; wbDatI = 32'h0;
    {genHigh, genLow, fA, fM, cA, cM, gpioHigh, gpioLow} = 8'h00;
    c = 16'hC000; mismatches = 0; nTests = 0; cyc = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    tReg;
    tOwn;
    tModes;
    tForce;
    end_sim;
  end
endmodule
